// *** rtl/mcu_instruction_execute.sv ***
// instruction execute core: accumulator, flags, data memory and flow
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_execute
   import exec_pkg::*;
#(
   parameter int          MEM_DEPTH = 160,
   parameter int          ADDR_W    = 8,
   parameter int          PC_W      = 12,
   parameter int          STK_DEPTH = 6,
   parameter logic [11:0] IRQ_VEC   = 12'h004
) (
   // clock and reset
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_n,
   // instruction
   input  wire logic              i_op_valid,
   input  wire exec_pkg::op_t     i_op,
   input  wire logic [ADDR_W-1:0] i_mem_addr,
   input  wire logic [7:0]        i_imm,
   input  wire logic [PC_W-1:0]   i_target,
   // external events
   input  wire logic              i_call_push,
   input  wire logic [PC_W-1:0]   i_call_addr,
   input  wire logic              i_irq_pending,
   input  wire logic              i_wdog_timeout,
   input  wire logic              i_wake,
   input  wire logic              i_flag_load,
   input  wire logic              i_carry_in,
   input  wire logic              i_half_carry_in,
   // status
   output logic                   o_ready,
   output logic [PC_W-1:0]        o_pc,
   output logic [7:0]             o_acc,
   output logic                   o_zero_flag,
   output logic                   o_carry_flag,
   output logic                   o_half_carry_flag,
   output logic                   o_timeout_flag,
   output logic                   o_powerdown_flag,
   output logic                   o_global_irq_enable,
   // watchdog, clock control and interrupt acknowledge
   output logic                   o_wdog_clear,
   output logic                   o_prescaler_clear,
   output logic                   o_clock_gated,
   output logic                   o_irq_ack
);
   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      state_t                     st;
      logic                       ready;
      logic [PC_W-1:0]            pc;
      logic [7:0]                 acc;
      logic                       z;
      logic                       c;
      logic                       hc;
      logic                       to;
      logic                       pwdn;
      logic                       gie;
      preclr_t                    last;
      logic                       wclr;
      logic                       pclr;
      logic                       iack;
      logic                       gated;
      logic [MEM_DEPTH-1:0][7:0]  mem;
   } core_t;
   core_t      r_reg;
   core_t      r_next;
   logic       take;
   logic [7:0] rd_data;
   logic [7:0] alu_res;
   logic       alu_z;
   logic       alu_c;
   logic       pop;
   logic [PC_W-1:0] stk_top;
   // ************************************************
   // decode helpers
   // ************************************************
   function automatic logic writes_mem(input op_t op);
      return op inside {OP_INV_MEM, OP_DEC_ADJ, OP_DEC_MEM, OP_INC_MEM,
                        OP_MOV_A2M, OP_OR_MEM, OP_ROL_MEM};
   endfunction
   function automatic logic writes_acc(input op_t op);
      return op inside {OP_INV_ACC, OP_DEC_ACC, OP_INC_ACC, OP_MOV_M2A,
                        OP_MOV_X2A, OP_OR_M2A, OP_OR_X2A, OP_RET_IMM,
                        OP_ROL_ACC};
   endfunction
   function automatic logic sets_zero(input op_t op);
      return op inside {OP_INV_MEM, OP_INV_ACC, OP_DEC_MEM, OP_DEC_ACC,
                        OP_INC_MEM, OP_INC_ACC, OP_OR_M2A, OP_OR_X2A,
                        OP_OR_MEM};
   endfunction

   // ************************************************
   // datapath
   // ************************************************
   assign take = r_reg.ready && i_op_valid;
   assign rd_data = (int'(i_mem_addr) < MEM_DEPTH) ?
                    r_reg.mem[i_mem_addr] : BYTE_ZERO;
   assign pop = take && (i_op == OP_SUB_RET || i_op == OP_RET_IMM ||
                (i_op == OP_IRQ_RET && !i_irq_pending));
   exec_alu u_alu (
      .i_op         (i_op),
      .i_acc        (r_reg.acc),
      .i_mem        (rd_data),
      .i_imm        (i_imm),
      .i_carry      (r_reg.c),
      .i_half_carry (r_reg.hc),
      .o_result     (alu_res),
      .o_zero       (alu_z),
      .o_carry      (alu_c)
   );
   ret_stack #(
      .DEPTH (STK_DEPTH),
      .W     (PC_W)
   ) u_stack (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_push      (i_call_push),
      .i_push_addr (i_call_addr),
      .i_pop       (pop),
      .o_top       (stk_top)
   );

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      r_next      = r_reg;
      r_next.wclr = 1'b0;
      r_next.pclr = 1'b0;
      r_next.iack = 1'b0;
      if (i_flag_load) begin
         r_next.c  = i_carry_in;
         r_next.hc = i_half_carry_in;
      end
      case (r_reg.st)
         ST_DUMMY: r_next.st = ST_EXEC;
         ST_HALT: begin
            if (i_wake) begin
               r_next.st = ST_EXEC;
            end
         end
         default: begin
            if (take) begin
               r_next.pc = r_reg.pc + 1'b1;
               if (writes_mem(i_op) && int'(i_mem_addr) < MEM_DEPTH) begin
                  r_next.mem[i_mem_addr] = alu_res;
               end
               if (writes_acc(i_op)) begin
                  r_next.acc = alu_res;
               end
               if (sets_zero(i_op)) begin
                  r_next.z = alu_z;
               end
               if (i_op == OP_DEC_ADJ) begin
                  r_next.c = alu_c;
               end
               case (i_op)
                  OP_PRECLR_A, OP_PRECLR_B: begin
                     if ((i_op == OP_PRECLR_A && r_reg.last == PRE_B) ||
                         (i_op == OP_PRECLR_B && r_reg.last == PRE_A)) begin
                        r_next.wclr = 1'b1;
                        r_next.to   = 1'b0;
                        r_next.pwdn = 1'b0;
                        r_next.last = PRE_NONE;
                     end else begin
                        r_next.last = (i_op == OP_PRECLR_A) ?
                                      PRE_A : PRE_B;
                     end
                  end
                  OP_POWERDOWN: begin
                     r_next.st   = ST_HALT;
                     r_next.wclr = 1'b1;
                     r_next.pclr = 1'b1;
                     r_next.pwdn = 1'b1;
                     r_next.to   = 1'b0;
                  end
                  OP_JUMP: begin
                     r_next.pc = i_target;
                     r_next.st = ST_DUMMY;
                  end
                  OP_SUB_RET, OP_RET_IMM: begin
                     r_next.pc = stk_top;
                     r_next.st = ST_DUMMY;
                  end
                  OP_IRQ_RET: begin
                     r_next.st = ST_DUMMY;
                     if (i_irq_pending) begin
                        r_next.pc   = IRQ_VEC[PC_W-1:0];
                        r_next.gie  = 1'b0;
                        r_next.iack = 1'b1;
                     end else begin
                        r_next.pc  = stk_top;
                        r_next.gie = 1'b1;
                     end
                  end
                  default: ;
               endcase
            end
         end
      endcase
      if (i_wdog_timeout) begin
         r_next.to = 1'b1;
      end
      r_next.ready = (r_next.st == ST_EXEC);
      r_next.gated = (r_next.st == ST_HALT);
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r_reg       <= '0;
         r_reg.st    <= ST_EXEC;
         r_reg.ready <= 1'b1;
         r_reg.last  <= PRE_NONE;
      end else begin
         r_reg <= r_next;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   assign o_ready             = r_reg.ready;
   assign o_pc                = r_reg.pc;
   assign o_acc               = r_reg.acc;
   assign o_zero_flag         = r_reg.z;
   assign o_carry_flag        = r_reg.c;
   assign o_half_carry_flag   = r_reg.hc;
   assign o_timeout_flag      = r_reg.to;
   assign o_powerdown_flag    = r_reg.pwdn;
   assign o_global_irq_enable = r_reg.gie;
   assign o_wdog_clear        = r_reg.wclr;
   assign o_prescaler_clear   = r_reg.pclr;
   assign o_clock_gated       = r_reg.gated;
   assign o_irq_ack           = r_reg.iack;

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_dummy_then_ready;
      !o_ready ##1 o_ready;
   endsequence
   property p_preclr_repeat;
      take && i_op == OP_PRECLR_A && r_reg.last == PRE_A && !i_wdog_timeout
      |=> !o_wdog_clear && $stable(o_timeout_flag) &&
          $stable(o_powerdown_flag);
   endproperty
   a_preclr_repeat: assert property (p_preclr_repeat)
      else $error("repeated pre-clear had an effect");
   property p_preclr_pair;
      take && i_op == OP_PRECLR_B && r_reg.last == PRE_A && !i_wdog_timeout
      |=> o_wdog_clear && !o_timeout_flag && !o_powerdown_flag;
   endproperty
   a_preclr_pair: assert property (p_preclr_pair)
      else $error("pre-clear pair did not clear");
   property p_inv_acc;
      take && i_op == OP_INV_ACC && !i_flag_load
      |=> o_acc == ~$past(rd_data) && o_zero_flag == (o_acc == BYTE_ZERO);
   endproperty
   a_inv_acc: assert property (p_inv_acc)
      else $error("complement to acc wrong");
   property p_inc_acc;
      take && i_op == OP_INC_ACC |=> o_acc == $past(rd_data) + BYTE_ONE;
   endproperty
   a_inc_acc: assert property (p_inc_acc)
      else $error("increment to acc wrong");
   property p_or_imm;
      take && i_op == OP_OR_X2A |=> o_acc == ($past(o_acc) | $past(i_imm));
   endproperty
   a_or_imm: assert property (p_or_imm)
      else $error("or immediate wrong");
   property p_powerdown;
      take && i_op == OP_POWERDOWN && !i_wake && !i_wdog_timeout
      |=> o_clock_gated && o_powerdown_flag && !o_timeout_flag &&
          o_wdog_clear && o_prescaler_clear
          ##1 (o_clock_gated || $past(i_wake));
   endproperty
   a_powerdown: assert property (p_powerdown)
      else $error("power-down entry wrong");
   property p_halt_hold;
      o_clock_gated && !i_flag_load |=> $stable(o_acc) && $stable(o_pc);
   endproperty
   a_halt_hold: assert property (p_halt_hold)
      else $error("state moved while powered down");
   property p_jump;
      take && i_op == OP_JUMP
      |=> o_pc == $past(i_target) && $stable(o_zero_flag) ##0
          s_dummy_then_ready;
   endproperty
   a_jump: assert property (p_jump)
      else $error("jump timing or target wrong");
   property p_mov_imm;
      take && i_op == OP_MOV_X2A && !i_flag_load
      |=> o_acc == $past(i_imm) && $stable(o_zero_flag) &&
          $stable(o_carry_flag);
   endproperty
   a_mov_imm: assert property (p_mov_imm)
      else $error("move immediate wrong");
   property p_irq_ret;
      take && i_op == OP_IRQ_RET
      |=> (o_global_irq_enable != $past(i_irq_pending)) &&
          (o_irq_ack == $past(i_irq_pending)) ##0 s_dummy_then_ready;
   endproperty
   a_irq_ret: assert property (p_irq_ret)
      else $error("interrupt return wrong");
endmodule
`default_nettype wire

// *** inc/exec_pkg.sv ***
// constants and types shared by the instruction execute core
package exec_pkg;
   // ************************************************
   // instruction codes
   // ************************************************
   typedef enum logic [4:0] {
      OP_NOP       = 5'h00,
      OP_PRECLR_A  = 5'h01,
      OP_PRECLR_B  = 5'h02,
      OP_INV_MEM   = 5'h03,
      OP_INV_ACC   = 5'h04,
      OP_DEC_ADJ   = 5'h05,
      OP_DEC_MEM   = 5'h06,
      OP_DEC_ACC   = 5'h07,
      OP_INC_MEM   = 5'h08,
      OP_INC_ACC   = 5'h09,
      OP_POWERDOWN = 5'h0A,
      OP_JUMP      = 5'h0B,
      OP_MOV_M2A   = 5'h0C,
      OP_MOV_X2A   = 5'h0D,
      OP_MOV_A2M   = 5'h0E,
      OP_OR_M2A    = 5'h0F,
      OP_OR_X2A    = 5'h10,
      OP_OR_MEM    = 5'h11,
      OP_SUB_RET   = 5'h12,
      OP_RET_IMM   = 5'h13,
      OP_IRQ_RET   = 5'h14,
      OP_ROL_MEM   = 5'h15,
      OP_ROL_ACC   = 5'h16
   } op_t;

   typedef enum logic [1:0] {
      ST_EXEC  = 2'h0,
      ST_DUMMY = 2'h1,
      ST_HALT  = 2'h2
   } state_t;

   typedef enum logic [1:0] {
      PRE_NONE = 2'h0,
      PRE_A    = 2'h1,
      PRE_B    = 2'h2
   } preclr_t;

   // ************************************************
   // arithmetic constants
   // ************************************************
   localparam logic [3:0] NIB_MAX    = 4'h9;
   localparam logic [7:0] ADJ_NONE   = 8'h00;
   localparam logic [7:0] ADJ_LO     = 8'h06;
   localparam logic [7:0] ADJ_HI     = 8'h60;
   localparam logic [7:0] BYTE_ONE   = 8'h01;
   localparam logic [7:0] BYTE_ZERO  = 8'h00;
endpackage

// *** rtl/exec_alu.sv ***
// result and flag computation for the execute core
`timescale 1ns/1ps
`default_nettype none
module exec_alu
   import exec_pkg::*;
(
   // operation
   input  wire exec_pkg::op_t i_op,
   // operands
   input  wire logic [7:0]    i_acc,
   input  wire logic [7:0]    i_mem,
   input  wire logic [7:0]    i_imm,
   input  wire logic          i_carry,
   input  wire logic          i_half_carry,
   // results
   output logic [7:0]         o_result,
   output logic               o_zero,
   output logic               o_carry
);
   logic [7:0] adj;
   logic [8:0] sum9;

   always_comb begin
      adj = ADJ_NONE;
      if ((i_acc[3:0] > NIB_MAX) || i_half_carry) begin
         adj = adj | ADJ_LO;
      end
      if ((i_acc[7:4] > NIB_MAX) || i_carry) begin
         adj = adj | ADJ_HI;
      end
      sum9 = {1'b0, i_acc} + {1'b0, adj};
      o_carry = i_carry;
      case (i_op)
         OP_INV_MEM, OP_INV_ACC: o_result = ~i_mem;
         OP_DEC_ADJ: begin
            o_result = sum9[7:0];
            o_carry  = sum9[8] | i_carry;
         end
         OP_DEC_MEM, OP_DEC_ACC: o_result = i_mem - BYTE_ONE;
         OP_INC_MEM, OP_INC_ACC: o_result = i_mem + BYTE_ONE;
         OP_MOV_M2A:             o_result = i_mem;
         OP_MOV_X2A, OP_RET_IMM: o_result = i_imm;
         OP_MOV_A2M:             o_result = i_acc;
         OP_OR_M2A, OP_OR_MEM:   o_result = i_acc | i_mem;
         OP_OR_X2A:              o_result = i_acc | i_imm;
         OP_ROL_MEM, OP_ROL_ACC: o_result = {i_mem[6:0], i_mem[7]};
         default:                o_result = i_acc;
      endcase
      o_zero = (o_result == BYTE_ZERO);
   end
endmodule
`default_nettype wire

// *** rtl/ret_stack.sv ***
// hardware return-address stack, top at entry zero
`timescale 1ns/1ps
`default_nettype none
module ret_stack #(
   parameter int DEPTH = 6,
   parameter int W     = 12
) (
   // clock and reset
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst_n,
   // control
   input  wire logic         i_push,
   input  wire logic [W-1:0] i_push_addr,
   input  wire logic         i_pop,
   // top of stack
   output logic [W-1:0]      o_top
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] ent;
   } stk_t;

   stk_t stk_reg;
   stk_t stk_next;

   always_comb begin
      stk_next = stk_reg;
      if (i_push) begin
         stk_next.ent = {stk_reg.ent[DEPTH-2:0], i_push_addr};
      end else if (i_pop) begin
         stk_next.ent = {stk_reg.ent[DEPTH-1], stk_reg.ent[DEPTH-1:1]};
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stk_reg <= '0;
      end else begin
         stk_reg <= stk_next;
      end
   end

   assign o_top = stk_reg.ent[0];
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the instruction execute core
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import exec_pkg::*;
   // ************************************************
   // signals
   // ************************************************
   logic        i_ref_clk;
   logic        i_rst_n;
   logic        i_op_valid;
   op_t         i_op;
   logic [7:0]  i_mem_addr;
   logic [7:0]  i_imm;
   logic [11:0] i_target;
   logic        i_call_push;
   logic [11:0] i_call_addr;
   logic        i_irq_pending;
   logic        i_wdog_timeout;
   logic        i_wake;
   logic        i_flag_load;
   logic        i_carry_in;
   logic        i_half_carry_in;
   logic        o_ready;
   logic [11:0] o_pc;
   logic [7:0]  o_acc;
   logic        o_zero_flag;
   logic        o_carry_flag;
   logic        o_half_carry_flag;
   logic        o_timeout_flag;
   logic        o_powerdown_flag;
   logic        o_global_irq_enable;
   logic        o_wdog_clear;
   logic        o_prescaler_clear;
   logic        o_clock_gated;
   logic        o_irq_ack;
   int          n_errors;
   int          checks;
   int          cycles;
   // adjust cases: accumulator, {carry, half-carry}, sum, carry after
   logic [7:0]  adj_acc [6] = '{8'h12, 8'h12, 8'hA2, 8'h12, 8'hAA, 8'h99};
   logic [1:0]  adj_fl  [6] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h0};
   logic [7:0]  adj_sum [6] = '{8'h12, 8'h18, 8'h02, 8'h72, 8'h10, 8'h99};
   logic        adj_c   [6] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0};

   mcu_instruction_execute DUT (
      .i_ref_clk           (i_ref_clk),
      .i_rst_n             (i_rst_n),
      .i_op_valid          (i_op_valid),
      .i_op                (i_op),
      .i_mem_addr          (i_mem_addr),
      .i_imm               (i_imm),
      .i_target            (i_target),
      .i_call_push         (i_call_push),
      .i_call_addr         (i_call_addr),
      .i_irq_pending       (i_irq_pending),
      .i_wdog_timeout      (i_wdog_timeout),
      .i_wake              (i_wake),
      .i_flag_load         (i_flag_load),
      .i_carry_in          (i_carry_in),
      .i_half_carry_in     (i_half_carry_in),
      .o_ready             (o_ready),
      .o_pc                (o_pc),
      .o_acc               (o_acc),
      .o_zero_flag         (o_zero_flag),
      .o_carry_flag        (o_carry_flag),
      .o_half_carry_flag   (o_half_carry_flag),
      .o_timeout_flag      (o_timeout_flag),
      .o_powerdown_flag    (o_powerdown_flag),
      .o_global_irq_enable (o_global_irq_enable),
      .o_wdog_clear        (o_wdog_clear),
      .o_prescaler_clear   (o_prescaler_clear),
      .o_clock_gated       (o_clock_gated),
      .o_irq_ack           (o_irq_ack)
   );

   // ************************************************
   // tasks
   // ************************************************
   task automatic end_of_test;
      if (n_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [11:0] exp,
                      input logic [11:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one instruction; returns at the falling edge after it is taken
   task automatic run(input op_t op, input logic [7:0] addr,
                      input logic [7:0] imm, input logic [11:0] tgt);
      int n;
      n = 0;
      @(negedge i_ref_clk);
      while (o_ready !== 1'h1 && n < 20) begin
         @(negedge i_ref_clk);
         n++;
      end
      i_op_valid = 1'h1;
      i_op = op;
      i_mem_addr = addr;
      i_imm = imm;
      i_target = tgt;
      @(negedge i_ref_clk);
      i_op_valid = 1'h0;
   endtask

   // one-cycle pulse on {wake, timeout, push}
   task automatic kick(input logic [2:0] k);
      @(negedge i_ref_clk);
      {i_wake, i_wdog_timeout, i_call_push} = k;
      @(negedge i_ref_clk);
      {i_wake, i_wdog_timeout, i_call_push} = 3'h0;
   endtask

   task automatic load_flags(input logic c, input logic h);
      @(negedge i_ref_clk);
      i_flag_load = 1'h1;
      i_carry_in = c;
      i_half_carry_in = h;
      @(negedge i_ref_clk);
      i_flag_load = 1'h0;
   endtask

   // ************************************************
   // clock, timeout and sequence
   // ************************************************
   always #20 i_ref_clk = ~i_ref_clk;

   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         end_of_test();
      end
   end

   initial begin
      {i_ref_clk, i_rst_n, i_op_valid, i_call_push, i_irq_pending} = 5'h0;
      {i_wdog_timeout, i_wake, i_flag_load, i_carry_in} = 4'h0;
      i_half_carry_in = 1'h0;
      i_op = OP_NOP;
      {i_mem_addr, i_imm, i_target, i_call_addr} = 40'h0;
      {n_errors, checks, cycles} = '0;
      repeat (20) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      chk("reset ready", 12'h1, 12'(o_ready));
      chk("reset acc", 12'h0, 12'(o_acc));
      i_rst_n = 1'h1;
      // moves and or
      run(OP_MOV_X2A, 8'h00, 8'h5A, 12'h000);
      chk("acc", 12'h05A, 12'(o_acc));
      run(OP_MOV_A2M, 8'h10, 8'h00, 12'h000);
      run(OP_MOV_X2A, 8'h00, 8'h00, 12'h000);
      chk("zero", 12'h0, 12'(o_zero_flag));
      run(OP_OR_X2A, 8'h00, 8'h00, 12'h000);
      chk("zero", 12'h1, 12'(o_zero_flag));
      run(OP_OR_M2A, 8'h10, 8'h00, 12'h000);
      chk("acc", 12'h05A, 12'(o_acc));
      chk("zero", 12'h0, 12'(o_zero_flag));
      run(OP_OR_X2A, 8'h00, 8'h81, 12'h000);
      chk("acc", 12'h0DB, 12'(o_acc));
      run(OP_MOV_X2A, 8'h00, 8'h24, 12'h000);
      run(OP_OR_MEM, 8'h10, 8'h00, 12'h000);
      chk("acc", 12'h024, 12'(o_acc));
      run(OP_MOV_M2A, 8'h10, 8'h00, 12'h000);
      chk("mem", 12'h07E, 12'(o_acc));
      // increment and decrement
      run(OP_MOV_X2A, 8'h00, 8'hFF, 12'h000);
      run(OP_MOV_A2M, 8'h20, 8'h00, 12'h000);
      run(OP_INC_MEM, 8'h20, 8'h00, 12'h000);
      chk("zero", 12'h1, 12'(o_zero_flag));
      chk("acc", 12'h0FF, 12'(o_acc));
      run(OP_INC_ACC, 8'h20, 8'h00, 12'h000);
      chk("acc", 12'h001, 12'(o_acc));
      chk("zero", 12'h0, 12'(o_zero_flag));
      run(OP_DEC_ACC, 8'h20, 8'h00, 12'h000);
      chk("acc", 12'h0FF, 12'(o_acc));
      run(OP_MOV_M2A, 8'h20, 8'h00, 12'h000);
      chk("mem", 12'h000, 12'(o_acc));
      run(OP_DEC_MEM, 8'h20, 8'h00, 12'h000);
      chk("acc", 12'h000, 12'(o_acc));
      run(OP_MOV_M2A, 8'h20, 8'h00, 12'h000);
      chk("mem", 12'h0FF, 12'(o_acc));
      // complement
      run(OP_INV_ACC, 8'h20, 8'h00, 12'h000);
      chk("acc", 12'h000, 12'(o_acc));
      chk("zero", 12'h1, 12'(o_zero_flag));
      run(OP_INV_MEM, 8'h20, 8'h00, 12'h000);
      chk("acc", 12'h000, 12'(o_acc));
      run(OP_MOV_M2A, 8'h20, 8'h00, 12'h000);
      chk("mem", 12'h000, 12'(o_acc));
      // rotate left
      run(OP_MOV_X2A, 8'h00, 8'h81, 12'h000);
      run(OP_MOV_A2M, 8'h40, 8'h00, 12'h000);
      run(OP_ROL_ACC, 8'h40, 8'h00, 12'h000);
      chk("acc", 12'h003, 12'(o_acc));
      chk("zero", 12'h1, 12'(o_zero_flag));
      run(OP_ROL_MEM, 8'h40, 8'h00, 12'h000);
      chk("acc", 12'h003, 12'(o_acc));
      run(OP_MOV_M2A, 8'h40, 8'h00, 12'h000);
      chk("mem", 12'h003, 12'(o_acc));
      // decimal adjust
      for (int i = 0; i < 6; i++) begin
         run(OP_MOV_X2A, 8'h00, adj_acc[i], 12'h000);
         load_flags(adj_fl[i][1], adj_fl[i][0]);
         run(OP_DEC_ADJ, 8'h30, 8'h00, 12'h000);
         chk("adj carry", 12'(adj_c[i]), 12'(o_carry_flag));
         chk("adj acc", 12'(adj_acc[i]), 12'(o_acc));
         chk("adj hc", 12'(adj_fl[i][0]), 12'(o_half_carry_flag));
         run(OP_MOV_M2A, 8'h30, 8'h00, 12'h000);
         chk("adj sum", 12'(adj_sum[i]), 12'(o_acc));
      end
      // no-op and jump
      run(OP_NOP, 8'h30, 8'h55, 12'h000);
      chk("acc", 12'h099, 12'(o_acc));
      run(OP_JUMP, 8'h00, 8'h00, 12'h123);
      chk("pc", 12'h123, o_pc);
      chk("ready", 12'h0, 12'(o_ready));
      chk("carry", 12'h0, 12'(o_carry_flag));
      @(negedge i_ref_clk);
      chk("ready", 12'h1, 12'(o_ready));
      run(OP_NOP, 8'h00, 8'h00, 12'h000);
      chk("pc", 12'h124, o_pc);
      // returns
      i_call_addr = 12'h456;
      kick(3'h1);
      i_call_addr = 12'h789;
      kick(3'h1);
      run(OP_SUB_RET, 8'h00, 8'h00, 12'h000);
      chk("pc", 12'h789, o_pc);
      run(OP_RET_IMM, 8'h00, 8'h3C, 12'h000);
      chk("pc", 12'h456, o_pc);
      chk("acc", 12'h03C, 12'(o_acc));
      i_call_addr = 12'h2AB;
      kick(3'h1);
      i_irq_pending = 1'h1;
      run(OP_IRQ_RET, 8'h00, 8'h00, 12'h000);
      chk("pc", 12'h004, o_pc);
      chk("irq ack", 12'h1, 12'(o_irq_ack));
      chk("gie", 12'h0, 12'(o_global_irq_enable));
      i_irq_pending = 1'h0;
      run(OP_IRQ_RET, 8'h00, 8'h00, 12'h000);
      chk("pc", 12'h2AB, o_pc);
      chk("gie", 12'h1, 12'(o_global_irq_enable));
      // power-down, refused request, wake
      kick(3'h2);
      chk("timeout", 12'h1, 12'(o_timeout_flag));
      run(OP_POWERDOWN, 8'h00, 8'h00, 12'h000);
      chk("gated", 12'h1, 12'(o_clock_gated));
      chk("ready", 12'h0, 12'(o_ready));
      chk("wdog clr", 12'h1, 12'(o_wdog_clear));
      chk("presc clr", 12'h1, 12'(o_prescaler_clear));
      chk("pd flag", 12'h1, 12'(o_powerdown_flag));
      chk("timeout", 12'h0, 12'(o_timeout_flag));
      i_op = OP_MOV_X2A;
      i_imm = 8'h77;
      i_op_valid = 1'h1;
      repeat (2) @(negedge i_ref_clk);
      i_op_valid = 1'h0;
      chk("acc", 12'h03C, 12'(o_acc));
      kick(3'h4);
      chk("ready", 12'h1, 12'(o_ready));
      chk("pd flag", 12'h1, 12'(o_powerdown_flag));
      // watchdog pre-clear pairing
      kick(3'h2);
      run(OP_PRECLR_A, 8'h00, 8'h00, 12'h000);
      chk("wdog clr", 12'h0, 12'(o_wdog_clear));
      run(OP_PRECLR_A, 8'h00, 8'h00, 12'h000);
      chk("wdog clr", 12'h0, 12'(o_wdog_clear));
      chk("timeout", 12'h1, 12'(o_timeout_flag));
      chk("pd flag", 12'h1, 12'(o_powerdown_flag));
      run(OP_PRECLR_B, 8'h00, 8'h00, 12'h000);
      chk("wdog clr", 12'h1, 12'(o_wdog_clear));
      chk("timeout", 12'h0, 12'(o_timeout_flag));
      chk("pd flag", 12'h0, 12'(o_powerdown_flag));
      kick(3'h2);
      run(OP_PRECLR_B, 8'h00, 8'h00, 12'h000);
      chk("wdog clr", 12'h0, 12'(o_wdog_clear));
      run(OP_PRECLR_A, 8'h00, 8'h00, 12'h000);
      chk("wdog clr", 12'h1, 12'(o_wdog_clear));
      chk("timeout", 12'h0, 12'(o_timeout_flag));
      end_of_test();
   end
endmodule
`default_nettype wire
